//--- design/nsled_blink.sv
// Blink generator: lit phase then dark phase, repeating.
// Assumes i_restart pulses when the pattern is (re)entered.
`timescale 1ns/1ps
`default_nettype none
module nsled_blink #(
	parameter int unsigned LIT_CYC = nsled_pkg::LIT_CYCLES,
	parameter int unsigned DARK_CYC = nsled_pkg::DARK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_run,
	input wire logic i_restart,
	output logic o_lit
);
	import nsled_pkg::*;

	localparam logic [TMR_W-1:0] LIT_LAST = TMR_W'(LIT_CYC - 1);
	localparam logic [TMR_W-1:0] DARK_LAST = TMR_W'(DARK_CYC - 1);

	logic [TMR_W-1:0] count;
	logic lit;

	// -------------------------------------------------------------
	// Phase timer
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || !i_run) begin
			count <= '0;
			lit <= 1'b1; // Parked at the start of the lit phase
		end else if (i_restart) begin
			// Entry cycle already shows lit, so it is the first lit cycle
			count <= (LIT_LAST == '0) ? '0 : TMR_W'(1);
			lit <= (LIT_LAST != '0);
		end else if (lit && count == LIT_LAST) begin
			count <= '0;
			lit <= 1'b0; // 1 s lit done
		end else if (!lit && count == DARK_LAST) begin
			count <= '0;
			lit <= 1'b1; // 2 s dark done
		end else begin
			count <= count + 1'b1;
		end
	end

	assign o_lit = lit;
endmodule : nsled_blink
`default_nettype wire

//--- design/nsled_pkg.sv
// Constants and carriers for the network status indicator driver.
// Assumes a single 50 MHz clock domain.
package nsled_pkg;
	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	localparam int unsigned CLK_HZ = 50000000;
	localparam int unsigned LIT_TIME_MS = 1000;
	localparam int unsigned DARK_TIME_MS = 2000;
	localparam int unsigned LIT_CYCLES = (CLK_HZ / 1000) * LIT_TIME_MS;
	localparam int unsigned DARK_CYCLES = (CLK_HZ / 1000) * DARK_TIME_MS;
	localparam int unsigned TMR_W = 32;

	// -------------------------------------------------------------
	// Pin function select values
	// -------------------------------------------------------------
	localparam logic [1:0] PIN_FUNC_GPIO_IN = 2'h0;
	localparam logic [1:0] PIN_FUNC_GPIO_OUT = 2'h1;
	localparam logic [1:0] PIN_FUNC_ALT_LED = 2'h2;
	localparam logic [1:0] PIN_FUNC_RESET = 2'h0;

	// -------------------------------------------------------------
	// Network state codes
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		NSLED_NET_OFF = 3'h0,
		NSLED_NET_NOT_REG = 3'h1,
		NSLED_NET_REG_IDLE = 3'h2,
		NSLED_NET_REG_PSAVE = 3'h3,
		NSLED_NET_CONNECTING = 3'h4
	} nsled_net_t;

	// Pin configuration command
	typedef struct packed {
		logic valid;
		logic [1:0] func;
		logic value;
	} nsled_pin_cmd_t;

	// Pin drive bundle
	typedef struct packed {
		logic out;
		logic oe;
	} nsled_pin_t;
endpackage : nsled_pkg

//--- design/nsled_top.sv
// Network status indicator driver on general pin one.
// Assumes state inputs synchronous to i_clk; an external transistor drives the LED.
//
// How it works
// - The indicator output reports network service availability and call state.
// - The indicator drives the pin only once a configuration command selects the alternate function; before that the pin is plain GPIO.
// - Not registered holds the indicator steadily lit.
// - Registered idle blinks lit one second then dark two seconds.
// - Connecting uses the same one second lit, two seconds dark blink.
// - Registered idle in power saving follows the paging-synchronised wakeup event.
`timescale 1ns/1ps
`default_nettype none
module nsled_top #(
	parameter int unsigned LIT_CYC = nsled_pkg::LIT_CYCLES,
	parameter int unsigned DARK_CYC = nsled_pkg::DARK_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire nsled_pkg::nsled_pin_cmd_t i_pin_cmd,
	input wire nsled_pkg::nsled_net_t i_net_state,
	input wire logic i_wake_event,
	input wire logic i_pin_in,
	output logic o_pin_out,
	output logic o_pin_oe,
	output logic o_gpio_in,
	output logic o_alt_active
);
	import nsled_pkg::*;

	logic [1:0] func;
	logic gpio_value;
	logic gpio_in;
	nsled_net_t prev_state;
	logic blink_mode;
	logic restart;
	logic blink_lit;
	logic lamp;
	nsled_pin_t next_pin;
	nsled_pin_t pin;

	// -------------------------------------------------------------
	// Pin configuration
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			func <= PIN_FUNC_RESET;
			gpio_value <= 1'b0;
		end else if (i_pin_cmd.valid) begin
			func <= i_pin_cmd.func; // Alternate function only by command
			gpio_value <= i_pin_cmd.value;
		end
	end

	// Input readback; meaningful in input mode
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			gpio_in <= 1'b0;
		end else begin
			gpio_in <= i_pin_in;
		end
	end

	// -------------------------------------------------------------
	// Blink entry detect
	// -------------------------------------------------------------
	assign blink_mode = (i_net_state == NSLED_NET_REG_IDLE) ||
		(i_net_state == NSLED_NET_CONNECTING);

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			prev_state <= NSLED_NET_OFF;
		end else begin
			prev_state <= i_net_state;
		end
	end

	// Idle and connecting share one pattern, so moving between them keeps phase
	assign restart = blink_mode && !((prev_state == NSLED_NET_REG_IDLE) ||
		(prev_state == NSLED_NET_CONNECTING));

	nsled_blink #(
		.LIT_CYC(LIT_CYC),
		.DARK_CYC(DARK_CYC)
	) u_blink (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_run(blink_mode),
		.i_restart(restart),
		.o_lit(blink_lit)
	);

	// -------------------------------------------------------------
	// Lamp pattern from network state
	// -------------------------------------------------------------
	always_comb begin
		unique case (i_net_state)
			NSLED_NET_OFF: lamp = 1'b0;
			NSLED_NET_NOT_REG: lamp = 1'b1; // Steady, no blink
			NSLED_NET_REG_IDLE: lamp = blink_lit;
			NSLED_NET_CONNECTING: lamp = blink_lit;
			NSLED_NET_REG_PSAVE: lamp = i_wake_event; // Paging-timed wakeup
			default: lamp = 1'b0;
		endcase
	end

	always_comb begin
		next_pin.out = 1'b0;
		next_pin.oe = 1'b0;
		unique case (func)
			PIN_FUNC_ALT_LED: begin
				next_pin.out = lamp;
				next_pin.oe = 1'b1;
			end
			PIN_FUNC_GPIO_OUT: begin
				next_pin.out = gpio_value;
				next_pin.oe = 1'b1;
			end
			default: begin
				next_pin.out = 1'b0; // Input: pin released
				next_pin.oe = 1'b0;
			end
		endcase
	end

	// -------------------------------------------------------------
	// Registered outputs
	// -------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			pin <= '0; // Dark and released in reset
		end else begin
			pin <= next_pin;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_alt_active <= 1'b0;
		end else begin
			o_alt_active <= (func == PIN_FUNC_ALT_LED);
		end
	end

	assign o_pin_out = pin.out;
	assign o_pin_oe = pin.oe;
	assign o_gpio_in = gpio_in;
endmodule : nsled_top
`default_nettype wire

//--- testbench/nsled_assertions.sv
// Checker on the indicator driver's ports.
// Bound into nsled_top after the module.
`timescale 1ns/1ps
`default_nettype none
module nsled_assertions #(
	parameter int unsigned LIT_CYC = 10,
	parameter int unsigned DARK_CYC = 20
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire nsled_pkg::nsled_pin_cmd_t i_pin_cmd,
	input wire nsled_pkg::nsled_net_t i_net_state,
	input wire logic i_wake_event,
	input wire logic o_pin_out,
	input wire logic o_pin_oe,
	input wire logic o_alt_active
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [2:0] st_q;
	logic st_same;
	logic st_ok;
	// State held over two samples with the alternate function on
	always_ff @(posedge i_clk) st_q <= i_net_state;
	always_ff @(posedge i_clk) st_same <= (i_net_state == st_q) && o_alt_active;
	assign st_ok = st_same & o_alt_active;
	a_reset_dark: assert property ($past(!i_rst_n) |-> !o_pin_out && !o_pin_oe)
		else $error("not dark after reset");
	a_alt_select: assert property (i_pin_cmd.valid && i_pin_cmd.func == 2'h2
		##1 !i_pin_cmd.valid |-> ##1 o_alt_active && o_pin_oe) else $error("alt not on");
	a_gpio_input: assert property (i_pin_cmd.valid && i_pin_cmd.func == 2'h0
		##1 !i_pin_cmd.valid |-> ##1 !o_pin_oe && !o_alt_active) else $error("pad driven");
	a_gpio_output: assert property (i_pin_cmd.valid && i_pin_cmd.func == 2'h1
		##1 !i_pin_cmd.valid |-> ##1 o_pin_oe && o_pin_out == $past(i_pin_cmd.value, 2))
		else $error("gpio output wrong");
	a_off_dark: assert property (st_ok && st_q == 3'h0 |-> !o_pin_out)
		else $error("lamp lit while off");
	a_unreg_lit: assert property (st_ok && st_q == 3'h1 |-> o_pin_out)
		else $error("lamp dark while unregistered");
	a_wake_follow: assert property (st_ok && st_q == 3'h3
		&& $past(i_wake_event, 2) == $past(i_wake_event) |-> o_pin_out == $past(i_wake_event))
		else $error("lamp not following wake");
	a_blink_enter: assert property (o_alt_active && i_net_state == 3'h2 && st_q == 3'h0
		|-> ##2 o_pin_out) else $error("blink not starting lit");
endmodule : nsled_assertions
bind nsled_top nsled_assertions #(.LIT_CYC(LIT_CYC), .DARK_CYC(DARK_CYC)) nsled_assertions_i (
	.i_clk, .i_rst_n, .i_pin_cmd, .i_net_state, .i_wake_event, .o_pin_out, .o_pin_oe,
	.o_alt_active);
`default_nettype wire

//--- testbench/nsled_led_model.sv
// Far side: transistor base on the pad, lamp on its collector.
// Assumes the pad pull-down holds the base low when undriven.
`timescale 1ns/1ps
`default_nettype none
module nsled_led_model (
	input wire logic i_drive,
	input wire logic i_oe,
	output logic o_lamp
);
	// Released pad falls to the pull-down, so the lamp goes dark
	assign o_lamp = i_oe & i_drive;
endmodule : nsled_led_model
`default_nettype wire

//--- testbench/test_nsled_top.sv
// Self-checking bench for the indicator driver with a lamp model.
// Assumes short blink counts; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module test_nsled_top;
	import nsled_pkg::*;
	localparam int LIT = 10;
	localparam int DARK = 20;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	nsled_pin_cmd_t i_pin_cmd = '0;
	nsled_net_t i_net_state = NSLED_NET_OFF;
	logic i_wake_event = 1'b0;
	logic ext = 1'b0;
	logic i_pin_in, o_pin_out, o_pin_oe, o_gpio_in, o_alt_active, lamp;
	int errors = 0, checks = 0, cycles = 0;
	integer seed = 32'h6596a488;
	nsled_net_t pick [4] = '{NSLED_NET_OFF, NSLED_NET_NOT_REG, NSLED_NET_REG_PSAVE, NSLED_NET_OFF};
	always #10 i_clk = ~i_clk;
	// Pad reads back its own drive, else the outside level
	assign i_pin_in = o_pin_oe ? o_pin_out : ext;
	nsled_top #(.LIT_CYC(LIT), .DARK_CYC(DARK)) nsled_top_i (.i_clk, .i_rst_n, .i_pin_cmd,
		.i_net_state, .i_wake_event, .i_pin_in, .o_pin_out, .o_pin_oe, .o_gpio_in, .o_alt_active);
	nsled_led_model nsled_led_model_i (.i_drive(o_pin_out), .i_oe(o_pin_oe), .o_lamp(lamp));
	function automatic logic exp_lamp(nsled_net_t s, logic w, int j);
		case (s)
			NSLED_NET_NOT_REG: return 1'b1;
			NSLED_NET_REG_PSAVE: return w;
			NSLED_NET_REG_IDLE, NSLED_NET_CONNECTING: return (j % (LIT + DARK)) < LIT;
			default: return 1'b0;
		endcase
	endfunction : exp_lamp
	task automatic check(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %b seen %b", name, exp, got);
		end
	endtask : check
	task automatic cmd(input logic [1:0] func, input logic value);
		@(negedge i_clk) i_pin_cmd = '{1'b1, func, value};
		@(negedge i_clk) i_pin_cmd = '0;
		@(negedge i_clk);
	endtask : cmd
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : print_verdict
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			print_verdict();
		end
	end
	initial begin
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		check("lamp", 1'b0, lamp);
		cmd(2'h1, 1'b1);
		check("lamp", 1'b1, lamp);
		cmd(2'h0, 1'b0);
		check("oe", 1'b0, o_pin_oe);
		repeat (6) begin
			@(negedge i_clk) ext = 1'($random(seed));
			@(negedge i_clk) check("gpio_in", ext, o_gpio_in);
		end
		// Network state must not reach the pad before the alternate function
		i_net_state = NSLED_NET_NOT_REG;
		repeat (2) @(negedge i_clk);
		check("lamp", 1'b0, lamp);
		cmd(2'h2, 1'b0);
		check("alt", 1'b1, o_alt_active);
		check("lamp", 1'b1, lamp);
		repeat (24) begin
			@(negedge i_clk) i_net_state = pick[$unsigned($random(seed)) % 4];
			i_wake_event = 1'($random(seed));
			repeat (2) @(negedge i_clk);
			check("lamp", exp_lamp(i_net_state, i_wake_event, 0), lamp);
		end
		@(negedge i_clk) i_net_state = NSLED_NET_OFF;
		@(negedge i_clk) i_net_state = NSLED_NET_REG_IDLE;
		for (int j = 0; j <= 60; j++) begin
			@(negedge i_clk) check("blink", exp_lamp(i_net_state, 1'b0, j), lamp);
			if (j == 15) i_net_state = NSLED_NET_CONNECTING;
		end
		// Reset in mid-run drops the alternate function and darkens the pad
		@(negedge i_clk) i_rst_n = 1'b0;
		repeat (2) @(negedge i_clk);
		i_rst_n = 1'b1;
		check("lamp", 1'b0, lamp);
		check("alt", 1'b0, o_alt_active);
		print_verdict();
	end
endmodule : test_nsled_top
`default_nettype wire
